// [hdl/wws_top.sv]
// Window watchdog supervisor core with strap-selected timing and open-drain reset.
// Assumes trigger and straps arrive from pins and the straps stay static in operation.
`timescale 1ns/1ns
`include "wws_cfg.svh"
module wws_top #(
	parameter longint WIN_SHORT_CYC = `WWS_WIN_SHORT_CYC,
	parameter longint WIN_LONG_CYC  = `WWS_WIN_LONG_CYC,
	parameter int     CAP_PF        = `WWS_CAP_PF_DEF,
	parameter int     TOL_PCT       = `WWS_TOL_NOM_PCT,
	parameter int     RST_PULSE_CYC = `WWS_RST_PULSE_CYC,
	parameter int     CNT_W         = `WWS_CNT_W
) (
	// Clock and reset.
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	// Trigger from the supervised processor.
	input  wire logic        trigger_in,
	// Static straps.
	input  wire logic [1:0]  window_length_sel_in,
	input  wire logic        window_ratio_sel_in,
	// Open-drain reset pin.
	output logic             reset_pin_out,
	output logic             reset_pin_oe_out,
	// Status.
	output logic             timeout_out,
	output logic             violation_out,
	output logic             lower_check_en_out,
	output wws_pkg::wws_len_t cfg_length_out,
	output logic             cfg_ratio_out
);
	import wws_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Derived timing.

	// Spread factor kept within the documented tolerance band.
	localparam longint TOL_USE = (TOL_PCT < `WWS_TOL_MIN_PCT) ? `WWS_TOL_MIN_PCT :
	                             (TOL_PCT > `WWS_TOL_MAX_PCT) ? `WWS_TOL_MAX_PCT : TOL_PCT;

	// Capacitor window: (C / 15.55 pF + 1) x 6.25 ms, in clock cycles.
	localparam longint CAP_NOM_CYC = ((longint'(CAP_PF) * 64'd100 + `WWS_CAP_STEP_PFX100) *
	                                  `WWS_CAP_BASE_US * 64'd1000) /
	                                 (`WWS_CAP_STEP_PFX100 * `WWS_CLK_NS);

	// Windows after spread, rounded down so a timeout never comes late.
	localparam longint WG = WIN_SHORT_CYC * TOL_USE / 100;
	localparam longint WV = WIN_LONG_CYC * TOL_USE / 100;
	localparam longint WC = CAP_NOM_CYC * TOL_USE / 100;

	localparam logic [CNT_W-1:0] WIN_GND = CNT_W'(WG);
	localparam logic [CNT_W-1:0] WIN_VDD = CNT_W'(WV);
	localparam logic [CNT_W-1:0] WIN_CAP = CNT_W'(WC);

	// Lower boundaries: window times ten over the ratio times ten.
	localparam logic [CNT_W-1:0] LB_HI_GND = CNT_W'(WG * 10 / `WWS_RATIO_HI_GND);
	localparam logic [CNT_W-1:0] LB_HI_VDD = CNT_W'(WV * 10 / `WWS_RATIO_HI_VDD);
	localparam logic [CNT_W-1:0] LB_HI_CAP = CNT_W'(WC * 10 / `WWS_RATIO_HI_CAP);
	localparam logic [CNT_W-1:0] LB_LO_GND = CNT_W'(WG * 10 / `WWS_RATIO_LO_GND);
	localparam logic [CNT_W-1:0] LB_LO_VDD = CNT_W'(WV * 10 / `WWS_RATIO_LO_VDD);
	localparam logic [CNT_W-1:0] LB_LO_CAP = CNT_W'(WC * 10 / `WWS_RATIO_LO_CAP);

	localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_PULSE_CYC - 1);
	localparam logic [CNT_W-1:0] CFG_LAST = CNT_W'(`WWS_CFG_WAIT_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection.

	logic [3:0]  pins_sync;
	logic        trig_s;
	logic [1:0]  len_s;
	logic        ratio_s;

	// Trigger and straps pass two flip-flops before any logic sees them.
	wws_sync #(
		.WIDTH      (4)
	) u_sync (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.async_in   ({trigger_in, window_length_sel_in, window_ratio_sel_in}),
		.sync_out   (pins_sync)
	);

	assign trig_s  = pins_sync[3];
	assign len_s   = pins_sync[2:1];
	assign ratio_s = pins_sync[0];

	logic        trig_d_reg;
	logic        trig_rise;

	// A rising edge is seen in the same cycle that the synchronised trigger first reads high.
	assign trig_rise = trig_s & ~trig_d_reg;

	////////////////////////////////////////////////////////////////////////////////
	// State.

	wws_state_t        state_reg;
	wws_state_t        state_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic [CNT_W-1:0]  cnt_next;
	logic              lower_en_reg;
	logic              lower_en_next;
	wws_len_t          len_reg;
	wws_len_t          len_next;
	logic              ratio_reg;
	logic              ratio_next;
	logic              rst_oe_reg;
	logic              timeout_reg;
	logic              violation_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Window selection from the captured straps.

	logic [CNT_W-1:0]  win_sel;
	logic [CNT_W-1:0]  lb_hi;
	logic [CNT_W-1:0]  lb_lo;
	logic [CNT_W-1:0]  lb_sel;
	logic [CNT_W-1:0]  win_last;

	// Length strap picks the window and the ratio pair; ratio strap picks the pair member.
	assign win_sel  = (len_reg == WWS_LEN_VDD) ? WIN_VDD :
	                  (len_reg == WWS_LEN_GND) ? WIN_GND : WIN_CAP;
	assign lb_hi    = (len_reg == WWS_LEN_VDD) ? LB_HI_VDD :
	                  (len_reg == WWS_LEN_GND) ? LB_HI_GND : LB_HI_CAP;
	assign lb_lo    = (len_reg == WWS_LEN_VDD) ? LB_LO_VDD :
	                  (len_reg == WWS_LEN_GND) ? LB_LO_GND : LB_LO_CAP;
	assign lb_sel   = ratio_reg ? lb_hi : lb_lo;
	assign win_last = win_sel - CNT_ONE;

	////////////////////////////////////////////////////////////////////////////////
	// Event decode in the running state.

	logic              in_run;
	logic              early_edge;
	logic              good_edge;
	logic              expired;

	// An edge inside the lower boundary counts only once checking is armed.
	assign in_run     = (state_reg == WWS_ST_RUN);
	assign early_edge = in_run & trig_rise & lower_en_reg & (cnt_reg < lb_sel);
	assign good_edge  = in_run & trig_rise & ~early_edge;
	// An edge in the last cycle still counts as in time.
	assign expired    = in_run & ~trig_rise & (cnt_reg >= win_last);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Straps settle, then run, then hold reset for a pulse after any fault.
	always_comb
	begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		lower_en_next = lower_en_reg;
		len_next      = len_reg;
		ratio_next    = ratio_reg;
		unique case (state_reg)
			WWS_ST_CFG:
			begin
				cnt_next = cnt_reg + CNT_ONE;
				if (cnt_reg >= CFG_LAST)
				begin
					len_next   = (len_s == 2'b00) ? WWS_LEN_GND :
					             (len_s == 2'b01) ? WWS_LEN_VDD : WWS_LEN_CAP;
					ratio_next = ratio_s;
					cnt_next   = '0;
					state_next = WWS_ST_RUN;
				end
			end
			WWS_ST_RUN:
			begin
				cnt_next = cnt_reg + CNT_ONE;
				if (good_edge)
				begin
					cnt_next      = '0;
					lower_en_next = 1'b1;
				end
				else if (early_edge || expired)
				begin
					cnt_next   = '0;
					state_next = WWS_ST_RESET;
				end
			end
			WWS_ST_RESET:
			begin
				cnt_next      = cnt_reg + CNT_ONE;
				lower_en_next = 1'b0;
				if (cnt_reg >= RST_LAST)
				begin
					cnt_next   = '0;
					state_next = WWS_ST_RUN;
				end
			end
			default:
			begin
				cnt_next   = '0;
				state_next = WWS_ST_CFG;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	// Control state and configuration.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			state_reg    <= WWS_ST_CFG;
			cnt_reg      <= '0;
			lower_en_reg <= 1'b0;
			len_reg      <= WWS_LEN_GND;
			ratio_reg    <= 1'b0;
			trig_d_reg   <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			lower_en_reg <= lower_en_next;
			len_reg      <= len_next;
			ratio_reg    <= ratio_next;
			trig_d_reg   <= trig_s;
		end
	end

	// Reset pin drive and fault pulses.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			rst_oe_reg    <= 1'b1;
			timeout_reg   <= 1'b0;
			violation_reg <= 1'b0;
		end
		else
		begin
			rst_oe_reg    <= (state_next != WWS_ST_RUN);
			timeout_reg   <= expired;
			violation_reg <= early_edge;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign reset_pin_out      = 1'b0;
	assign reset_pin_oe_out   = rst_oe_reg;
	assign timeout_out        = timeout_reg;
	assign violation_out      = violation_reg;
	assign lower_check_en_out = lower_en_reg;
	assign cfg_length_out     = len_reg;
	assign cfg_ratio_out      = ratio_reg;

endmodule : wws_top

// [hdl/wws_cfg.svh]
// Timing constants and window ratios of the window watchdog supervisor.
// Assumes a 125 MHz system clock; the window counts are derived from the printed times.
`ifndef WWS_CFG_SVH
`define WWS_CFG_SVH

// Clock period in nanoseconds.
`define WWS_CLK_NS          64'd8

// Fixed window lengths in milliseconds and their cycle counts.
`define WWS_WIN_SHORT_MS    64'd250
`define WWS_WIN_LONG_MS     64'd2500
`define WWS_WIN_SHORT_CYC   (`WWS_WIN_SHORT_MS * 64'd1000000 / `WWS_CLK_NS)
`define WWS_WIN_LONG_CYC    (`WWS_WIN_LONG_MS * 64'd1000000 / `WWS_CLK_NS)

// Capacitor window: step capacitance in hundredths of pF and base time in microseconds.
`define WWS_CAP_STEP_PFX100 64'd1555
`define WWS_CAP_BASE_US     64'd6250
`define WWS_CAP_PF_DEF      1555

// Oscillator spread limits in percent of nominal.
`define WWS_TOL_MIN_PCT     75
`define WWS_TOL_MAX_PCT     125
`define WWS_TOL_NOM_PCT     100

// Window ratios, scaled by ten.
`define WWS_RATIO_HI_GND    64'd1249
`define WWS_RATIO_HI_VDD    64'd1277
`define WWS_RATIO_HI_CAP    64'd645
`define WWS_RATIO_LO_GND    64'd318
`define WWS_RATIO_LO_VDD    64'd320
`define WWS_RATIO_LO_CAP    64'd258

// Reset pulse length, strap settle time and counter width.
`define WWS_RST_PULSE_CYC   16
`define WWS_CFG_WAIT_CYC    3
`define WWS_CNT_W           36

`endif

// [hdl/wws_pkg.sv]
// Types shared by the window watchdog supervisor.
// Assumes the constants header is compiled alongside.
package wws_pkg;

	// Strap level on the window length input.
	typedef enum logic [1:0] {
		WWS_LEN_GND = 2'b00,
		WWS_LEN_VDD = 2'b01,
		WWS_LEN_CAP = 2'b10
	} wws_len_t;

	// Supervisor states.
	typedef enum logic [1:0] {
		WWS_ST_CFG   = 2'b00,
		WWS_ST_RUN   = 2'b01,
		WWS_ST_RESET = 2'b10
	} wws_state_t;

endpackage : wws_pkg

// [hdl/wws_sync.sv]
// Two flip-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk_sys_in; only the second stage is read.
`timescale 1ns/1ns
module wws_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clk_sys_in,
	input  wire logic             reset_n_in,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// Both stages clear on reset; the first stage feeds only the second.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule : wws_sync

// [dv/wws_assertions.sv]
// Port checker for the window watchdog supervisor.
// Assumes it is bound to wws_top and sees only its ports.
`timescale 1ns/1ns
module wws_assertions import wws_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Pins and status.
	input wire logic trigger_in,
	input wire logic [1:0] window_length_sel_in,
	input wire logic window_ratio_sel_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_out,
	input wire logic timeout_out,
	input wire logic violation_out,
	input wire logic lower_check_en_out,
	input wire wws_len_t cfg_length_out,
	input wire logic cfg_ratio_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	wire fault = timeout_out || violation_out;
	// The open-drain pin only ever pulls low.
	a_pin_data_low: assert property (reset_pin_out == 1'b0)
		else $error("reset pin data not low");
	a_fault_pulse_len: assert property (fault |-> reset_pin_oe_out ##15 reset_pin_oe_out ##1 !reset_pin_oe_out)
		else $error("reset pulse length wrong");
	a_timeout_one_cycle: assert property (timeout_out |=> !timeout_out)
		else $error("timeout pulse too long");
	a_viol_one_cycle: assert property (violation_out |=> !violation_out)
		else $error("violation pulse too long");
	a_viol_needs_arm: assert property (violation_out |-> $past(lower_check_en_out))
		else $error("violation while unarmed");
	a_fault_disarms: assert property (fault |=> !lower_check_en_out)
		else $error("check still armed after fault");
	a_faults_apart: assert property (!(timeout_out && violation_out))
		else $error("timeout and violation together");
	a_straps_static: assert property (!reset_pin_oe_out && $past(!reset_pin_oe_out)
		|-> $stable(cfg_length_out) && $stable(cfg_ratio_out))
		else $error("captured strap changed");
	c_viol: cover property (violation_out);
	c_timeout: cover property (timeout_out);
	c_arm: cover property ($rose(lower_check_en_out));
endmodule : wws_assertions
////////////////////////////////////////////////////////////////
bind wws_top wws_assertions u_chk (
	.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .trigger_in(trigger_in),
	.window_length_sel_in(window_length_sel_in), .window_ratio_sel_in(window_ratio_sel_in),
	.reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out),
	.timeout_out(timeout_out), .violation_out(violation_out),
	.lower_check_en_out(lower_check_en_out), .cfg_length_out(cfg_length_out),
	.cfg_ratio_out(cfg_ratio_out));

// [dv/wws_proc_model.sv]
// Model of the supervised processor driving the trigger pin.
// Assumes the bench raises fire_in for one cycle per wanted edge.
`timescale 1ns/1ns
module wws_proc_model (
	// Clock.
	input  wire logic clk_sys_in,
	// Request in, trigger pin out.
	input  wire logic fire_in,
	output logic      trigger_out = 1'b0
);
	int hold_reg = 0;
	// Each request gives one rising edge held high four cycles.
	always_ff @(posedge clk_sys_in)
	begin
		if (fire_in)
			hold_reg <= 4;
		else if (hold_reg > 0)
			hold_reg <= hold_reg - 1;
		trigger_out <= fire_in || hold_reg > 1;
	end
endmodule : wws_proc_model

// [dv/window_watchdog_supervisor_test.sv]
// Self-checking bench for the window watchdog supervisor.
// Assumes scaled windows of 2000 and 20000 cycles.
`timescale 1ns/1ns
`include "wws_cfg.svh"
module window_watchdog_supervisor_test;
	import wws_pkg::*;
	localparam int WS = 2000;
	localparam int WL = 20000;
	logic clk_sys_in = 0;
	logic reset_n_in = 0;
	logic fire = 0;
	logic seen;
	logic [1:0] len_sel = 0;
	logic ratio_sel = 0;
	wire trig, pin, oe, tmo, vio, arm, cfg_r;
	wws_len_t cfg_l;
	int n_errors = 0, total_checks = 0, cyc = 0;
	int win, bnd, r10, n;
	int exp_q[$];
	int pulse_len = 0;
	logic pulse_on = 0;
	wws_proc_model u_proc (.clk_sys_in(clk_sys_in), .fire_in(fire), .trigger_out(trig));
	wws_top #(.WIN_SHORT_CYC(WS), .WIN_LONG_CYC(WL)) DUT (
		.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .trigger_in(trig),
		.window_length_sel_in(len_sel), .window_ratio_sel_in(ratio_sel),
		.reset_pin_out(pin), .reset_pin_oe_out(oe), .timeout_out(tmo),
		.violation_out(vio), .lower_check_en_out(arm),
		.cfg_length_out(cfg_l), .cfg_ratio_out(cfg_r));
	// Clock and hang guard.
	initial forever #4 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_errors++;
			complete_run();
		end
	end
	// Compares one value and reports a mismatch.
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (exp !== got)
		begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic step(int k);
		repeat (k) @(posedge clk_sys_in);
	endtask : step
	// Fires one edge after d idle cycles, then watches eight cycles.
	task automatic trig_edge(int d);
		step(d);
		fire <= 1;
		step(1);
		fire <= 0;
		seen = 0;
		repeat (8)
		begin
			@(posedge clk_sys_in);
			seen |= vio === 1'b1;
		end
	endtask : trig_edge
	task automatic complete_run;
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	// Reference model: a queue of expected fault codes (1 violation, 2 timeout), one per design result,
	// and a count of the reset pulse that follows each fault unless a bench reset cuts it short.
	always @(posedge clk_sys_in)
	begin
		if (vio === 1'b1 || tmo === 1'b1)
			check("fault kind", exp_q.size() > 0 ? exp_q.pop_front() : 0, {tmo, vio});
		if (!reset_n_in)
			pulse_on <= 1'b0;
		else if (vio === 1'b1 || tmo === 1'b1)
		begin
			pulse_on  <= 1'b1;
			pulse_len <= 1;
		end
		else if (pulse_on && oe === 1'b1)
			pulse_len <= pulse_len + 1;
		else if (pulse_on)
		begin
			pulse_on <= 1'b0;
			check("reset pulse", `WWS_RST_PULSE_CYC, pulse_len);
		end
	end
	// Main sequence over six strap settings; edge spacing is d plus nine.
	initial
	begin
		void'($urandom(32'h91C9));
		for (int c = 0; c < 6; c++)
		begin
			len_sel <= 2'(c < 4 ? c / 2 : c - 2);
			ratio_sel <= c[0];
			win = c[1] ? WL : WS;
			r10 = c[0] ? (c[1] ? 1277 : 1249) : (c[1] ? 320 : 318);
			bnd = win * 10 / r10;
			reset_n_in <= 0;
			step(4);
			check("oe in reset", 1, oe);
			reset_n_in <= 1;
			step(5);
			check("cfg length", c < 4 ? c / 2 : WWS_LEN_CAP, cfg_l);
			check("cfg ratio", c[0], cfg_r);
			check("oe run", 0, oe);
			trig_edge(4);
			check("first edge", 0, seen);
			check("armed", 1, arm);
			if (c < 4)
			begin
				trig_edge(bnd - 6 + $urandom % 40);
				check("late edge", 0, seen);
			end
			// Capacitor boundaries are millions of cycles, so any quick second edge is early there.
			exp_q.push_back(1);
			trig_edge(c < 4 ? bnd - 12 : 4);
			check("early edge", 1, seen);
			n = 0;
			while (oe === 1'b1 && n < 100)
			begin
				step(1);
				n++;
			end
			check("pulse end", 1, n < 20);
			check("disarmed", 0, arm);
			trig_edge(4);
			check("edge after fault", 0, seen);
			if (c < 4)
			begin
				exp_q.push_back(2);
				n = 0;
				while (tmo !== 1'b1 && n < win + 50)
				begin
					step(1);
					n++;
				end
				check("timeout time", 1, n >= win - 8 && n <= win + 2);
				check("oe on timeout", 1, oe);
			end
		end
		check("events left", 0, exp_q.size());
		complete_run();
	end
endmodule : window_watchdog_supervisor_test
